/* File: core/adcctl_pkg.sv */
// Package for the converter control block: register map, fields, codes.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package adcctl_pkg;
  // Register byte offsets.
  localparam logic [3:0] ADCCTL_OFS_CTRL = 4'h0;
  localparam logic [3:0] ADCCTL_OFS_RESULT = 4'h4;
  localparam logic [3:0] ADCCTL_OFS_CLKDIV = 4'h8;
  localparam logic [3:0] ADCCTL_OFS_IRQ_STATUS = 4'hC;
  localparam logic [3:0] ADCCTL_OFS_IRQ_MASK = 4'h0;
  localparam logic [4:0] ADCCTL_OFS_MASK_WORD = 5'h10;
  // Control register field positions.
  localparam int ADCCTL_DONE_BIT = 7;
  localparam int ADCCTL_IEN_BIT = 6;
  localparam int ADCCTL_CONT_BIT = 5;
  // Channel codes.
  localparam logic [4:0] ADCCTL_CH_LAST_INPUT = 5'h06;
  localparam logic [4:0] ADCCTL_CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] ADCCTL_CH_REF_LOW = 5'h1E;
  localparam logic [4:0] ADCCTL_CH_POWER_OFF = 5'h1F;
  // Reset values.
  localparam logic [7:0] ADCCTL_CTRL_RESET = 8'h1F;
  localparam logic [2:0] ADCCTL_DIV_RESET = 3'h0;
  // Converter clock cycles per conversion.
  localparam logic [4:0] ADCCTL_CONV_CYCLES = 5'h10;
endpackage

/* File: core/adcctl_tick_if.sv */
// Interface carrying the converter clock tick between prescaler and core.
// Assumes both ends sit on sys_clk_i.
`timescale 1ns/1ps
interface adcctl_tick_if;
  logic [2:0] prescale_field;
  logic restart;
  logic tick;
  modport src (input prescale_field, input restart, output tick);
  modport dst (output prescale_field, output restart, input tick);
endinterface

/* File: core/adcctl_prescaler.sv */
// Prescaler: divides the bus clock into one-cycle converter ticks.
// Assumes synchronous active-high reset on the same clock.
`timescale 1ns/1ps
module adcctl_prescaler
  import adcctl_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Tick link.
  adcctl_tick_if.src tk
);
  logic [3:0] count;
  logic [3:0] limit;
  // Codes with the top bit set all divide by sixteen.
  assign limit = tk.prescale_field[2] ? 4'hF :
                 4'((4'h1 << tk.prescale_field[1:0]) - 4'h1);

  // Count restarts with each conversion so the period begins cleanly.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tk.restart || count >= limit) begin
      count <= 4'h0;
    end else begin
      count <= count + 4'h1;
    end
  end

  assign tk.tick = !rst_i && !tk.restart && (count >= limit);
endmodule

/* File: core/adcctl_top.sv */
// Converter control logic: registers, sequencer, interrupt, pin override.
// Assumes classic Wishbone on sys_clk_i and an analog core that latches
// its sample on each converter tick and offers an 8-bit code at the end.
// Timing of one conversion, as seen from the register bus:
// The control write is taken on the edge at which the request is seen.
// On that edge the sequencer enters its converting state.
// The prescaler count is cleared on the same edge.
// This means the first converter tick comes one divider period later.
// Sixteen ticks make one conversion; the sixteenth tick is its end.
// At that end edge the result is loaded and the flag or request is set.
// The busy output covers the end edge as well.
// This lets the analog side see its last tick while still marked busy.
// In continuous mode the next conversion follows without a gap.
// A power-off write ends a conversion with no result; a stop request does too, unless it comes on the last tick, which still loads the result.
// Hazard: a write and a completion in one cycle favour the write.
// That way the new settings are never mixed with a stale result.
// Limitation: the done flag reports only the latest conversion.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module adcctl_top
  import adcctl_pkg::*;
#(
  parameter int PIN_COUNT = 7
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt.
  output logic irq_o,
  // Low-power stop request.
  input wire logic stop_mode_i,
  // Analog core.
  input wire logic [7:0] analog_result_i,
  output logic [4:0] mux_select_o,
  output logic analog_power_o,
  output logic sample_tick_o,
  output logic conv_active_o,
  // Port pin override.
  input wire logic [PIN_COUNT-1:0] port_in_i,
  output logic [PIN_COUNT-1:0] pin_is_analog_o,
  output logic [PIN_COUNT-1:0] port_read_o
);
  initial begin
    if (PIN_COUNT < 1 || PIN_COUNT > 7) begin
      $error("PIN_COUNT must be 1 to 7");
    end
  end

  typedef enum logic [2:0] {
    ADCCTL_IDLE = 3'b001,
    ADCCTL_CONV = 3'b010,
    ADCCTL_OFF = 3'b100
  } adcctl_state_t;

  adcctl_state_t state;
  adcctl_state_t next_state;
  logic conv_irq_enable;
  logic continuous_mode_bit;
  logic conv_done_flag;
  logic irq_req;
  logic [4:0] channel_select_field;
  logic [2:0] prescale_field;
  logic [7:0] conv_result;
  logic [4:0] tick_count;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic pending;
  logic [PIN_COUNT-1:0] port_s1;
  logic [PIN_COUNT-1:0] port_s2;
  logic [PIN_COUNT-1:0] port_s3;
  logic [PIN_COUNT-1:0] port_stable;

  adcctl_tick_if tk ();

  adcctl_prescaler u_pre (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tk(tk)
  );

  // Bus decode; ack is a single cycle answer one edge after the request.
  wire bus_req = cyc_i && stb_i && !ack_o;
  wire lane0 = sel_i[0];
  wire wr_ctrl = bus_req && we_i && lane0 && adr_i == {1'b0, ADCCTL_OFS_CTRL};
  wire wr_div = bus_req && we_i && lane0 &&
                adr_i == {1'b0, ADCCTL_OFS_CLKDIV};
  wire wr_mask = bus_req && we_i && lane0 && adr_i == ADCCTL_OFS_MASK_WORD;
  wire rd_result = bus_req && !we_i &&
                   adr_i == {1'b0, ADCCTL_OFS_RESULT};
  wire rd_status = bus_req && !we_i &&
                   adr_i == {1'b0, ADCCTL_OFS_IRQ_STATUS};
  wire [4:0] new_ch = dat_i[4:0];
  wire stopped = stop_mode_i;
  wire power_off = channel_select_field == ADCCTL_CH_POWER_OFF;
  wire last_tick = tk.tick &&
                   tick_count == 5'(ADCCTL_CONV_CYCLES - 5'h1);
  wire conv_end = state == ADCCTL_CONV && last_tick && !wr_ctrl;
  // A control write restarts unless it selects power-off or stop is requested, carrying the new channel and mode.
  wire start = wr_ctrl && new_ch != ADCCTL_CH_POWER_OFF && !stopped;
  wire [7:0] ctrl_read = {conv_done_flag, conv_irq_enable,
                          continuous_mode_bit, channel_select_field};
  // Busy through the end edge, unless a stop cuts the conversion short.
  // Ticks are only shown while busy, so no tick leaks past an abort.
  wire busy_next = next_state == ADCCTL_CONV ||
                   (conv_end && !stopped);

  // Sequencer next state.
  always_comb begin
    next_state = state;
    unique case (state)
      ADCCTL_IDLE: begin
        if (start) begin
          next_state = ADCCTL_CONV;
        end else if (power_off) begin
          next_state = ADCCTL_OFF;
        end
      end
      ADCCTL_CONV: begin
        if (stopped || (wr_ctrl && !start)) begin
          next_state = ADCCTL_IDLE;
        end else if (conv_end && !continuous_mode_bit) begin
          next_state = ADCCTL_IDLE;
        end
      end
      ADCCTL_OFF: begin
        if (start) begin
          next_state = ADCCTL_CONV;
        end else if (!power_off) begin
          next_state = ADCCTL_IDLE;
        end
      end
      default: next_state = ADCCTL_IDLE;
    endcase
  end

  // The prescaler restarts whenever a fresh conversion begins.
  assign tk.prescale_field = prescale_field;
  assign tk.restart = start || (state != ADCCTL_CONV);

  // Sequencer state and tick counter; continuous mode wraps the count.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ADCCTL_OFF;
      tick_count <= 5'h00;
    end else begin
      state <= next_state;
      if (start || conv_end) begin
        tick_count <= 5'h00;
      end else if (state == ADCCTL_CONV && tk.tick) begin
        tick_count <= tick_count + 5'h01;
      end
    end
  end

  // Control fields; reset leaves interrupts off and single mode.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      conv_irq_enable <= 1'b0;
      continuous_mode_bit <= 1'b0;
      channel_select_field <= ADCCTL_CTRL_RESET[4:0];
      prescale_field <= ADCCTL_DIV_RESET;
    end else begin
      if (wr_ctrl) begin
        conv_irq_enable <= dat_i[ADCCTL_IEN_BIT];
        continuous_mode_bit <= dat_i[ADCCTL_CONT_BIT];
        channel_select_field <= new_ch;
      end
      if (wr_div) begin
        prescale_field <= dat_i[7:5];
      end
    end
  end

  // Result register; unused channel codes convert whatever the core
  // returns, so the value is undefined for those codes.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      conv_result <= 8'h00;
    end else if (conv_end) begin
      conv_result <= analog_result_i;
    end
  end

  // Done flag and converter request; a new completion beats a clear.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      conv_done_flag <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      if (conv_end && !conv_irq_enable) begin
        conv_done_flag <= 1'b1;
      end else if (wr_ctrl || rd_result) begin
        conv_done_flag <= 1'b0;
      end
      if (conv_end && conv_irq_enable) begin
        irq_req <= 1'b1;
      end else if (wr_ctrl || rd_result) begin
        irq_req <= 1'b0;
      end
    end
  end

  // Sticky status: bit0 completion, bit1 request; a read clears both.
  wire [1:0] events = {conv_end && conv_irq_enable, conv_end};
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      irq_status <= events | (rd_status ? 2'h0 : irq_status);
      if (wr_mask) begin
        irq_mask <= dat_i[1:0];
      end
    end
  end

  // The request level stays until its clear, so it feeds the output too.
  assign pending = |(irq_status & irq_mask) || irq_req;

  // Read mux; unmapped words read zero and still acknowledge.
  logic [31:0] next_dat;
  always_comb begin
    next_dat = 32'h0000_0000;
    if (adr_i == {1'b0, ADCCTL_OFS_CTRL}) begin
      next_dat = {24'h000000, ctrl_read};
    end else if (adr_i == {1'b0, ADCCTL_OFS_RESULT}) begin
      next_dat = {24'h000000, conv_result};
    end else if (adr_i == {1'b0, ADCCTL_OFS_CLKDIV}) begin
      next_dat = {24'h000000, prescale_field, 5'h00};
    end else if (adr_i == {1'b0, ADCCTL_OFS_IRQ_STATUS}) begin
      next_dat = {30'h0, irq_status};
    end else if (adr_i == ADCCTL_OFS_MASK_WORD) begin
      next_dat = {30'h0, irq_mask};
    end
  end

  // Bus answer and converter outputs, all from flip-flops.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      mux_select_o <= ADCCTL_CH_POWER_OFF;
      analog_power_o <= 1'b0;
      sample_tick_o <= 1'b0;
      conv_active_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req && !we_i ? next_dat : 32'h0000_0000;
      irq_o <= pending;
      mux_select_o <= wr_ctrl ? new_ch : channel_select_field;
      analog_power_o <= next_state != ADCCTL_OFF && !stopped;
      // Gating by busy keeps the power-off and stop cases tick free.
      sample_tick_o <= state == ADCCTL_CONV && tk.tick && busy_next;
      conv_active_o <= busy_next;
    end
  end

  // Three-stage pin synchroniser; a change counts once stages two and
  // three agree, and the first stage feeds only the second.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      port_s1 <= '0;
      port_s2 <= '0;
      port_s3 <= '0;
      port_stable <= '0;
    end else begin
      port_s1 <= port_in_i;
      port_s2 <= port_s1;
      port_s3 <= port_s2;
      port_stable <= (port_s2 & port_s3) | (port_stable & (port_s2 | port_s3));
    end
  end

  // Per pin override: the selected pin belongs to the converter.
  // Ownership follows the stored channel, so it moves one edge after the write edge.
  // A converter in its power-off state owns no pin; all pins read as digital.
  // Limitation: an owned pin reads zero even if its level is high.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      wire sel_here = channel_select_field == 5'(gi) &&
                      state != ADCCTL_OFF;
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          pin_is_analog_o[gi] <= 1'b0;
          port_read_o[gi] <= 1'b0;
        end else begin
          pin_is_analog_o[gi] <= sel_here;
          port_read_o[gi] <= sel_here ? 1'b0 : port_stable[gi];
        end
      end
    end
  endgenerate
endmodule

/* File: tb/adcctl_asserts.sv */
// Checker for the converter control block, bound to its top module.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/1ps
module adcctl_asserts #(
  parameter int PIN_COUNT = 7
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Bus and control.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic irq_o,
  input wire logic stop_mode_i,
  // Analog side and pins.
  input wire logic [7:0] analog_result_i,
  input wire logic [4:0] mux_select_o,
  input wire logic analog_power_o,
  input wire logic sample_tick_o,
  input wire logic conv_active_o,
  input wire logic [PIN_COUNT-1:0] port_in_i,
  input wire logic [PIN_COUNT-1:0] pin_is_analog_o,
  input wire logic [PIN_COUNT-1:0] port_read_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // A control write that picks a live channel outside stop mode must start a conversion.
  wire start_w = cyc_i && stb_i && we_i && !ack_o && adr_i == 5'h00 &&
    sel_i[0] && dat_i[4:0] != 5'h1F && !stop_mode_i;
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("Bus request not answered.");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("Ack held too long.");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("Read data outside ack.");
  conv_start_a: assert property (start_w |-> ##[1:3] conv_active_o)
    else $error("Control write started nothing.");
  power_off_a: assert property (mux_select_o == 5'h1F |->
    !conv_active_o && !sample_tick_o)
    else $error("Converter ran while off.");
  stop_halt_a: assert property (stop_mode_i |=> !conv_active_o)
    else $error("Conversion ran in stop mode.");
  tick_inside_a: assert property (sample_tick_o |-> conv_active_o)
    else $error("Tick outside conversion.");
  pin_zero_a: assert property ((port_read_o & pin_is_analog_o) == '0)
    else $error("Owned pin read not zero.");
  reset_quiet_a: assert property ($fell(rst_i) |->
    !irq_o && !conv_active_o)
    else $error("Busy right after reset.");
  // Main scenarios reached.
  cover property ($fell(conv_active_o));
  cover property ($rose(irq_o));
  cover property (stop_mode_i ##1 !conv_active_o);
endmodule
bind adcctl_top adcctl_asserts #(.PIN_COUNT(PIN_COUNT)) i_adcctl_asserts (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .stop_mode_i(stop_mode_i),
  .analog_result_i(analog_result_i), .mux_select_o(mux_select_o),
  .analog_power_o(analog_power_o), .sample_tick_o(sample_tick_o),
  .conv_active_o(conv_active_o), .port_in_i(port_in_i),
  .pin_is_analog_o(pin_is_analog_o), .port_read_o(port_read_o));

/* File: tb/adcctl_analog_model.sv */
// Behavioural analog core: gives a code derived from the selected channel.
// Assumes the block samples the code at the end of a conversion.
`timescale 1ns/1ps
module adcctl_analog_model (
  // Clock.
  input wire logic sys_clk_i,
  // Control from the block and the bench.
  input wire logic [4:0] mux_select_i,
  input wire logic analog_power_i,
  input wire logic [2:0] bias_i,
  // Code to the block.
  output logic [7:0] analog_result_o
);
  logic [7:0] code = 8'hA5;
  assign analog_result_o = code;
  // Unpowered, the code flips every cycle so a stale value never matches.
  always_ff @(posedge sys_clk_i) begin
    if (!analog_power_i) code <= ~code;
    else if (mux_select_i == 5'h1D) code <= 8'hFF;
    else if (mux_select_i == 5'h1E) code <= 8'h00;
    else code <= {bias_i, mux_select_i};
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes the analog model answers with a code built from the channel.
`timescale 1ns/1ps
module tb_top;
  import adcctl_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, stop = 0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, q, rdat;
  logic ack, irq, pwr, tick, act;
  logic [4:0] mux;
  logic [7:0] ares;
  logic [6:0] own, prd;
  logic [2:0] bias = 3'h3;
  logic [6:0] pins = 7'h7F;
  int failures = 0, checked = 0, n, ticks = 0, t0;
  logic [4:0] chans [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h1D, 5'h1E, 5'h08};
  // Clock at 50 MHz.
  initial begin
    forever #10 clk = ~clk;
  end
  adcctl_top i_adcctl_top (.sys_clk_i(clk), .rst_i(rst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
    .dat_o(rdat), .ack_o(ack), .irq_o(irq), .stop_mode_i(stop),
    .analog_result_i(ares), .mux_select_o(mux), .analog_power_o(pwr),
    .sample_tick_o(tick), .conv_active_o(act), .port_in_i(pins),
    .pin_is_analog_o(own), .port_read_o(prd));
  adcctl_analog_model i_adcctl_analog_model (.sys_clk_i(clk),
    .mux_select_i(mux), .analog_power_i(pwr), .bias_i(bias),
    .analog_result_o(ares));
  // Counts converter ticks shown to the analog side.
  always @(posedge clk) begin
    if (tick === 1'b1) ticks <= ticks + 1;
  end
  task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    if (k >= 20) failures++;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Waits for a conversion to start and end, counting cycles.
  task automatic conv(output int c);
    c = 0;
    while (act !== 1'b1 && c < 4) begin
      @(posedge clk);
      c++;
    end
    while (act === 1'b1 && c < 600) begin
      @(posedge clk);
      c++;
    end
    tk(2);
  endtask
  function automatic logic [31:0] expv(input logic [4:0] ch);
    if (ch == 5'h1D) return 32'hFF;
    if (ch == 5'h1E) return 32'h0;
    return {24'h0, bias, ch};
  endfunction
  task automatic t_reset;
    wb(0, 5'h00, 0); chk("ctrl", ADCCTL_CTRL_RESET, q);
    chk("irq", 0, irq);
    chk("power", 0, pwr);
    wb(0, 5'h14, 0); chk("unmapped", 0, q);
    wb(1, 5'h08, 32'hE0); wb(0, 5'h08, 0); chk("div", 32'hE0, q);
    $display("test reset done");
  endtask
  task automatic run(input logic [4:0] ch, input logic [2:0] dc);
    int d;
    d = dc[2] ? 16 : (1 << dc);
    wb(1, 5'h08, {24'h0, dc, 5'h0});
    t0 = ticks;
    wb(1, 5'h00, {27'h0, ch});
    conv(n);
    chk("len", 1, n >= 16 * d - 2 && n <= 16 * d + 6);
    chk("ticks", 16, ticks - t0);
    wb(0, 5'h00, 0); chk("done", 1, q[7]);
    wb(0, 5'h04, 0);
    if (ch < 5'h08 || ch > 5'h1C) chk("result", expv(ch), q);
    wb(0, 5'h00, 0); chk("done_clr", 0, q[7]);
    tk(20); chk("idle", 0, act);
    $display("test conv %h div %0d done", ch, d);
  endtask
  task automatic t_pin;
    wb(1, 5'h00, 32'h02); tk(6);
    chk("own", 7'h04, own);
    chk("pin_rd", 7'h7B, prd);
    pins <= 7'h55; tk(6);
    chk("pin_rd2", 7'h51, prd);
    pins <= 7'h7F;
    conv(n);
    $display("test pin done");
  endtask
  task automatic t_irq;
    wb(1, 5'h08, 0); wb(1, 5'h00, 32'h43); conv(n);
    chk("irq_on", 1, irq);
    wb(0, 5'h04, 0); tk(2); chk("irq_drop", 0, irq);
    wb(0, 5'h0C, 0); wb(1, 5'h10, 1); wb(1, 5'h00, 32'h03); conv(n);
    chk("irq_unmasked", 1, irq);
    wb(1, 5'h10, 0); tk(2); chk("irq_masked", 0, irq);
    wb(0, 5'h0C, 0); chk("status", 1, q);
    wb(1, 5'h10, 1); tk(2); chk("irq_clr", 0, irq);
    $display("test irq done");
  endtask
  task automatic t_cont;
    wb(1, 5'h00, 32'h24); tk(60); chk("cont", 1, act);
    bias <= 3'h6; tk(40);
    wb(0, 5'h04, 0); chk("cont_res", 32'hC4, q);
    wb(1, 5'h00, 32'h1F); tk(4); bias <= 3'h3;
    chk("off_act", 0, act);
    chk("off_pwr", 0, pwr);
    $display("test continuous done");
  endtask
  task automatic t_abort;
    // Divide by sixteen is the setting nearest the advised clock rate.
    wb(1, 5'h08, 32'h80);
    wb(1, 5'h00, 0); tk(50);
    wb(1, 5'h00, 32'h05); conv(n);
    chk("abort_len", 1, n >= 254 && n <= 262);
    wb(0, 5'h04, 0); chk("abort_res", expv(5'h05), q);
    $display("test abort done");
  endtask
  task automatic t_stop;
    wb(1, 5'h00, 32'h06); tk(20); stop <= 1; tk(3);
    chk("stop_act", 0, act);
    chk("stop_pwr", 0, pwr);
    tk(30); chk("stop_hold", 0, act);
    stop <= 0; wb(1, 5'h08, 0);
    wb(1, 5'h00, 32'h06); conv(n);
    run(5'h06, 3'h0);
    $display("test stop done");
  endtask
  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    tk(20000);
    failures++;
    end_of_test;
  end
  initial begin
    tk(4);
    rst <= 0;
    @(posedge clk);
    t_reset;
    for (int i = 0; i < 10; i++) run(chans[i], i[2:0]);
    t_pin;
    t_irq;
    t_cont;
    t_abort;
    t_stop;
    end_of_test;
  end
endmodule
